// file: logic/plpfm_pkg.sv
// Purpose: constants, field layout and carrier types of the indicator pin function mux
// Assumes: 16-bit management registers reached by word index; 250 MHz core clock
// Notes: byte address of a register on the bus is four times its index
// Notes on behaviour
// - pin 0 function codes map to sources.
// - pin 0 clock source: 5 PLL, 6 recovered.
// - pin 0 clock only when function is 1.
// - pin 1 clock source, same encoding, function 1.
// - pin 1 function codes, TX_ER and 25 MHz.
// - standard mode resets pin 1 to TX_ER.
// - extended mode resets pin 1 to reference clock, or to native when strapped.
// - pin 2 function codes, collision on 3/5/6.
// - extended mode bit 6 picks clock or pin1.
package plpfm_pkg;

   // register indices
   localparam logic [9:0] IDX_IO_CFG = 10'h302;
   localparam logic [9:0] IDX_PIN0 = 10'h303;
   localparam logic [9:0] IDX_PIN1 = 10'h304;
   localparam logic [9:0] IDX_PIN2 = 10'h305;
   localparam logic [9:0] IDX_STATUS = 10'h308;

   // field positions
   localparam int FUNC_LSB = 0;
   localparam int CLKSEL_LSB = 3;
   localparam int REFCLK_OFF_BIT = 6;
   localparam int STATUS_OFF_BIT = 0;

   // reset values
   localparam logic [15:0] PIN0_RESET = 16'h0008;
   localparam logic [15:0] PIN1_RESET_STD = 16'h000d;
   localparam logic [15:0] PIN1_RESET_EXT = 16'h000e;
   localparam logic [15:0] PIN1_RESET_EXT_NATIVE = 16'h0008;
   localparam logic [15:0] PIN2_RESET = 16'h0000;
   localparam logic [15:0] IO_CFG_RESET = 16'h0000;

   // function codes
   localparam logic [2:0] FN_NATIVE = 3'h0;
   localparam logic [2:0] FN_CLOCK = 3'h1;
   localparam logic [2:0] FN_WOL = 3'h2;
   localparam logic [2:0] FN_COL_A = 3'h3;
   localparam logic [2:0] FN_IRQ = 3'h4;
   localparam logic [2:0] FN_TXER = 3'h5;
   localparam logic [2:0] FN_REFCLK = 3'h6;
   localparam logic [2:0] FN_HIGH = 3'h7;

   // clock source codes
   localparam logic [2:0] CS_PLL = 3'h5;
   localparam logic [2:0] CS_REC = 3'h6;

   // external sources, all sampled into the core clock
   typedef struct packed {
      logic [2:0] native;
      logic pll_clk;
      logic rec_clk;
      logic wol;
      logic irq;
      logic tx_er;
      logic col;
      logic refclk;
   } plpfm_src_s;

   localparam int SRC_W = $bits(plpfm_src_s);

   typedef logic [15:0] plpfm_reg_t;

   // clock picked by a pin's clock source field, low when reserved
   function automatic logic plpfm_clock_pick(input logic [2:0] sel, input plpfm_src_s src);
      logic level;
      level = 1'b0;
      if (sel == CS_PLL) begin
         level = src.pll_clk;
      end else if (sel == CS_REC) begin
         level = src.rec_clk;
      end
      return level;
   endfunction

endpackage

// file: logic/plpfm_sync.sv
// Purpose: two-stage synchroniser for inputs from outside the core clock
// Assumes: each bit is independent; no bus coherence across bits
// Notes: no reset, so the first stage feeds only the second
`timescale 1ns/1ps
module plpfm_sync #(
   parameter int W = 1
) (
   // clock
   input wire logic clk_i,
   // data
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   import plpfm_pkg::*;

   logic [W-1:0] meta;

   // two flops in a row, nothing else reads meta
   always_ff @(posedge clk_i) begin
      meta <= d_i;
      q_o <= meta;
   end
endmodule

// file: logic/plpfm_pin_mux.sv
// Purpose: combinational source select for one indicator pin
// Assumes: sources already synchronised; PIN is 0, 1 or 2
// Notes: result is registered by the caller before it reaches a pin
`timescale 1ns/1ps
module plpfm_pin_mux #(
   parameter int PIN = 0
) (
   // selection
   input wire logic [2:0] func_i,
   input wire logic [2:0] clk_sel_i,
   // sources
   input wire plpfm_pkg::plpfm_src_s src_i,
   // result
   output logic level_o
);
   import plpfm_pkg::*;

   logic clock_level;
   logic level_p0;
   logic level_p1;
   logic level_p2;

   // clock reaches the pin only through function code 1
   assign clock_level = (func_i == FN_CLOCK) ? plpfm_clock_pick(clk_sel_i, src_i) : 1'b0;

   // pin 0: 3, 5, 6 low, 7 high
   assign level_p0 = (func_i == FN_NATIVE) ? src_i.native[0] :
                     (func_i == FN_CLOCK) ? clock_level :
                     (func_i == FN_WOL) ? src_i.wol :
                     (func_i == FN_IRQ) ? src_i.irq :
                     (func_i == FN_HIGH) ? 1'b1 : 1'b0;

   // pin 1: 3 and 7 reserved, held low
   assign level_p1 = (func_i == FN_NATIVE) ? src_i.native[1] :
                     (func_i == FN_CLOCK) ? clock_level :
                     (func_i == FN_WOL) ? src_i.wol :
                     (func_i == FN_IRQ) ? src_i.irq :
                     (func_i == FN_TXER) ? src_i.tx_er :
                     (func_i == FN_REFCLK) ? src_i.refclk : 1'b0;

   // pin 2: code 1 reserved and held low, collision on three codes
   assign level_p2 = (func_i == FN_NATIVE) ? src_i.native[2] :
                     (func_i == FN_WOL) ? src_i.wol :
                     (func_i == FN_COL_A || func_i == FN_TXER || func_i == FN_REFCLK) ? src_i.col :
                     (func_i == FN_IRQ) ? src_i.irq :
                     (func_i == FN_HIGH) ? 1'b1 : 1'b0;

   assign level_o = (PIN == 0) ? level_p0 : (PIN == 1) ? level_p1 : level_p2;
endmodule

// file: logic/plpfm_top.sv
// Purpose: indicator pin function mux with its configuration registers on classic Wishbone
// Assumes: straps and mode input are stable around reset; sources arrive from pins
// Notes: sampled clocks on the pins are only as good as 250 MHz sampling allows
//
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ps
module plpfm_top #(
   parameter logic FUNC_WRITABLE = 1'b1,
   parameter int ADR_W = 12
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // pinout mode and straps
   input wire logic extended_pinout_mode_i,
   input wire logic pin1_native_strap_i,
   // signal sources
   input wire plpfm_pkg::plpfm_src_s src_i,
   // indicator pins
   output logic indicator_pin_0_o,
   output logic indicator_pin_1_o,
   output logic indicator_pin_2_o
);
   import plpfm_pkg::*;

   // synchronised inputs
   logic [SRC_W+1:0] raw_in;
   logic [SRC_W+1:0] sync_in;
   plpfm_src_s src_s;
   logic ext_mode;
   logic native_strap;

   // configuration state
   logic [2:0] pin0_function_select;
   logic [2:0] pin0_clock_source;
   logic [2:0] pin1_function_select;
   logic [2:0] pin1_clock_source;
   logic [2:0] pin2_function_select;
   logic refclk_out_disable;

   // bus decode
   logic [9:0] reg_idx;
   logic bus_req;
   logic wr_lane0;
   logic hit_io;
   logic hit_pin0;
   logic hit_pin1;
   logic hit_pin2;
   logic hit_status;
   plpfm_reg_t rd_io;
   plpfm_reg_t rd_pin0;
   plpfm_reg_t rd_pin1;
   plpfm_reg_t rd_pin2;
   plpfm_reg_t rd_status;
   plpfm_reg_t rd_word;
   plpfm_reg_t pin1_reset_word;

   // mux results
   logic mux0;
   logic mux1;
   logic mux2;
   logic shared_pin1;

   // every external level passes two flops before use
   assign raw_in = {pin1_native_strap_i, extended_pinout_mode_i, src_i};

   plpfm_sync #(
      .W(SRC_W + 2)
   ) u_sync (
      .clk_i(clk_i),
      .d_i(raw_in),
      .q_o(sync_in)
   );

   assign src_s = sync_in[SRC_W-1:0];
   assign ext_mode = sync_in[SRC_W];
   assign native_strap = sync_in[SRC_W+1];

   // pin 1 default depends on mode and strap, taken while reset is held
   assign pin1_reset_word = !ext_mode ? PIN1_RESET_STD :
                            native_strap ? PIN1_RESET_EXT_NATIVE : PIN1_RESET_EXT;

   // word index from the byte address; low two bits are ignored
   assign reg_idx = wb_adr_i[11:2];
   assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   // every writable field sits in the low byte
   assign wr_lane0 = bus_req && wb_we_i && wb_sel_i[0];

   // address decode
   assign hit_io = (reg_idx == IDX_IO_CFG);
   assign hit_pin0 = (reg_idx == IDX_PIN0);
   assign hit_pin1 = (reg_idx == IDX_PIN1);
   assign hit_pin2 = (reg_idx == IDX_PIN2);
   assign hit_status = (reg_idx == IDX_STATUS);

   // read words, reserved bits read as zero
   assign rd_io = 16'h0000 | (16'(refclk_out_disable) << REFCLK_OFF_BIT);
   assign rd_pin0 = (16'(pin0_clock_source) << CLKSEL_LSB) | (16'(pin0_function_select) << FUNC_LSB);
   assign rd_pin1 = (16'(pin1_clock_source) << CLKSEL_LSB) | (16'(pin1_function_select) << FUNC_LSB);
   assign rd_pin2 = 16'(pin2_function_select) << FUNC_LSB;
   // status only means something in extended mode
   assign rd_status = 16'(refclk_out_disable && ext_mode) << STATUS_OFF_BIT;

   // unmapped indices read as zero
   assign rd_word = hit_io ? rd_io :
                    hit_pin0 ? rd_pin0 :
                    hit_pin1 ? rd_pin1 :
                    hit_pin2 ? rd_pin2 :
                    hit_status ? rd_status : 16'h0000;

   // io configuration, bit 6 steers the shared pin
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         refclk_out_disable <= IO_CFG_RESET[REFCLK_OFF_BIT];
      end else if (wr_lane0 && hit_io) begin
         refclk_out_disable <= wb_dat_i[REFCLK_OFF_BIT];
      end
   end

   // pin 0 configuration
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin0_clock_source <= PIN0_RESET[CLKSEL_LSB +: 3];
         pin0_function_select <= PIN0_RESET[FUNC_LSB +: 3];
      end else if (wr_lane0 && hit_pin0) begin
         pin0_clock_source <= wb_dat_i[CLKSEL_LSB +: 3];
         if (FUNC_WRITABLE) begin
            pin0_function_select <= wb_dat_i[FUNC_LSB +: 3];
         end
      end
   end

   // pin 1 configuration, reset value follows the synchronised straps
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin1_clock_source <= pin1_reset_word[CLKSEL_LSB +: 3];
         pin1_function_select <= pin1_reset_word[FUNC_LSB +: 3];
      end else if (wr_lane0 && hit_pin1) begin
         pin1_clock_source <= wb_dat_i[CLKSEL_LSB +: 3];
         if (FUNC_WRITABLE) begin
            pin1_function_select <= wb_dat_i[FUNC_LSB +: 3];
         end
      end
   end

   // pin 2 configuration, function field always writable
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin2_function_select <= PIN2_RESET[FUNC_LSB +: 3];
      end else if (wr_lane0 && hit_pin2) begin
         pin2_function_select <= wb_dat_i[FUNC_LSB +: 3];
      end
   end

   // single cycle ack; unmapped addresses also ack so a master never hangs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= bus_req;
         if (bus_req && !wb_we_i) begin
            wb_dat_o <= {16'h0000, rd_word};
         end
      end
   end

   // per-pin selection
   plpfm_pin_mux #(
      .PIN(0)
   ) u_mux0 (
      .func_i(pin0_function_select),
      .clk_sel_i(pin0_clock_source),
      .src_i(src_s),
      .level_o(mux0)
   );

   plpfm_pin_mux #(
      .PIN(1)
   ) u_mux1 (
      .func_i(pin1_function_select),
      .clk_sel_i(pin1_clock_source),
      .src_i(src_s),
      .level_o(mux1)
   );

   // pin 2 has no clock source field, so it is tied to a reserved code
   plpfm_pin_mux #(
      .PIN(2)
   ) u_mux2 (
      .func_i(pin2_function_select),
      .clk_sel_i(3'h0),
      .src_i(src_s),
      .level_o(mux2)
   );

   // extended mode with bit 6 clear puts the reference clock on the shared pin
   assign shared_pin1 = (ext_mode && !refclk_out_disable) ? src_s.refclk : mux1;

   // registered pins keep glitches of the select logic off the board
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         indicator_pin_0_o <= 1'b0;
         indicator_pin_1_o <= 1'b0;
         indicator_pin_2_o <= 1'b0;
      end else begin
         indicator_pin_0_o <= mux0;
         indicator_pin_1_o <= shared_pin1;
         indicator_pin_2_o <= mux2;
      end
   end
endmodule

// file: bench/plpfm_ref_pkg.sv
// Purpose: expected indicator level from a register image and the sources
// Assumes: r holds clock source in 5:3 and function in 2:0
// Notes: the pin 1 reference clock override is left to the caller
package plpfm_ref_pkg;
   import plpfm_pkg::*;
   // reserved codes give low, so an odd selection never blinks a pin
   function automatic logic plpfm_exp(input int p, input logic [5:0] r, input plpfm_src_s s);
      logic ck;
      ck = r[5:3] == 3'h5 ? s.pll_clk : r[5:3] == 3'h6 ? s.rec_clk : 1'b0;
      case (r[2:0])
         3'h0: return s.native[p];
         3'h1: return p != 2 && ck;
         3'h2: return s.wol;
         3'h4: return s.irq;
         3'h5: return p == 1 ? s.tx_er : p == 2 && s.col;
         3'h6: return p == 1 ? s.refclk : p == 2 && s.col;
         3'h7: return p != 1;
         default: return p == 2 && s.col;
      endcase
   endfunction
endpackage

// file: bench/plpfm_board.sv
// Purpose: board side sources for the indicator mux
// Assumes: bench sets static levels; clocks run only on request
// Notes: clocks are core clock dividers, so pin toggles can be counted
`timescale 1ns/1ps
module plpfm_board (
   // control
   input wire logic clk_i,
   input wire logic run_i,
   input wire plpfm_pkg::plpfm_src_s lvl_i,
   // sources
   output plpfm_pkg::plpfm_src_s src_o
);
   import plpfm_pkg::*;
   logic [3:0] cnt = 4'h0;
   // free divider, period 4 for the pll clock and 8 for the recovered one
   // plain always, so the start value may come from the declaration
   always @(posedge clk_i) begin
      cnt <= cnt + 4'h1;
   end
   // static levels unless clocks are asked for
   always_comb begin
      src_o = lvl_i;
      if (run_i) begin
         src_o.pll_clk = cnt[1];
         src_o.rec_clk = cnt[2];
      end
   end
endmodule

// file: bench/plpfm_top_monitor.sv
// Purpose: port level checks of the indicator mux
// Assumes: mode and strap stay fixed across each reset
// Notes: selection fields are shadowed from bus writes
`timescale 1ns/1ps
module plpfm_top_monitor #(
   parameter int ADR_W = 12
) (
   // clock, reset and bus
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // mode and strap
   input wire logic extended_pinout_mode_i,
   input wire logic pin1_native_strap_i,
   // sources and pins
   input wire plpfm_pkg::plpfm_src_s src_i,
   input wire logic indicator_pin_0_o,
   input wire logic indicator_pin_1_o,
   input wire logic indicator_pin_2_o
);
   import plpfm_pkg::*;
   import plpfm_ref_pkg::*;
   logic [5:0] r0, r1, r2;
   logic io6;
   logic [2:0] up;
   // a request counts only while ack is low, as the slave sees it
   wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire wr = take && wb_we_i && wb_sel_i[0];
   wire [9:0] idx = wb_adr_i[11:2];
   // shadow fields; up holds pin checks off until the sync stages refill
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r0 <= 6'h08;
         r1 <= !extended_pinout_mode_i ? 6'h0d : pin1_native_strap_i ? 6'h08 : 6'h0e;
         r2 <= 6'h00;
         io6 <= 1'b0;
         up <= 3'h0;
      end else begin
         if (up != 3'h4) up <= up + 3'h1;
         if (wr && idx == IDX_PIN0) r0 <= wb_dat_i[5:0];
         if (wr && idx == IDX_PIN1) r1 <= wb_dat_i[5:0];
         if (wr && idx == IDX_PIN2) r2 <= wb_dat_i[5:0];
         if (wr && idx == IDX_IO_CFG) io6 <= wb_dat_i[6];
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   chk_ack_latency: assert property (take |=> wb_ack_o) else $error("ack late");
   chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   chk_read_hold: assert property (!(take && !wb_we_i) |=> $stable(wb_dat_o)) else $error("data moved");
   chk_dat_upper: assert property (wb_dat_o[31:16] == 16'h0) else $error("upper data set");
   chk_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && wb_dat_o == 32'h0
      && !indicator_pin_0_o && !indicator_pin_1_o && !indicator_pin_2_o) else $error("busy in reset");
   chk_pin0_level:
   assert property (up == 3'h4 |-> indicator_pin_0_o == plpfm_exp(0, $past(r0), $past(src_i, 3)))
      else $error("pin 0 wrong");
   chk_pin1_level:
   assert property (up == 3'h4 |-> indicator_pin_1_o == (extended_pinout_mode_i && !$past(io6) ?
      $past(src_i.refclk, 3) : plpfm_exp(1, $past(r1), $past(src_i, 3)))) else $error("pin 1 wrong");
   chk_pin2_level:
   assert property (up == 3'h4 |-> indicator_pin_2_o == plpfm_exp(2, $past(r2), $past(src_i, 3)))
      else $error("pin 2 wrong");
   cover property (wr && idx == IDX_PIN0 && wb_dat_i[2:0] == 3'h1);
   cover property (take && !wb_we_i && idx == IDX_STATUS);
   cover property (extended_pinout_mode_i && io6 && up == 3'h4);
endmodule
bind plpfm_top plpfm_top_monitor #(.ADR_W(ADR_W)) u_mon (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
   .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .extended_pinout_mode_i,
   .pin1_native_strap_i, .src_i, .indicator_pin_0_o, .indicator_pin_1_o, .indicator_pin_2_o);

// file: bench/plpfm_top_test.sv
// Purpose: self-checking bench of the indicator mux
// Assumes: bus idle whenever reset is applied
// Notes: pins are judged 5 edges after a change, past the 3 edge latency
`timescale 1ns/1ps
module plpfm_top_test;
   import plpfm_pkg::*;
   import plpfm_ref_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [11:0] wb_adr_i = 12'h000;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
   logic wb_ack_o, indicator_pin_0_o, indicator_pin_1_o, indicator_pin_2_o;
   logic extended_pinout_mode_i = 1'b0, pin1_native_strap_i = 1'b0, run = 1'b0;
   plpfm_src_s lvl = '0, src_i;
   int error_cnt = 0, comparisons = 0, cycles = 0;
   wire [2:0] pins = {indicator_pin_2_o, indicator_pin_1_o, indicator_pin_0_o};
   always #2 clk_i = ~clk_i;
   plpfm_top u_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
      .wb_dat_i, .wb_dat_o, .wb_ack_o, .extended_pinout_mode_i, .pin1_native_strap_i, .src_i,
      .indicator_pin_0_o, .indicator_pin_1_o, .indicator_pin_2_o);
   plpfm_board u_board (.clk_i, .run_i(run), .lvl_i(lvl), .src_o(src_i));
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // a hang counts as a mismatch
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         test_done;
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // one classic cycle, held until the edge where ack is seen
   task automatic bus(input logic w, input logic [11:0] a, input logic [15:0] d, output logic [31:0] q);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= {16'h0, d};
      wb_sel_i <= 4'h1;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 16'h0, q);
      chk(q, e);
   endtask
   // counting rises over 32 edges shows which clock reached the pin
   task automatic rises(input int p, input logic [31:0] e);
      logic last;
      int n;
      n = 0;
      last = pins[p];
      repeat (32) begin
         @(posedge clk_i);
         if (pins[p] === 1'b1 && last === 1'b0) n++;
         last = pins[p];
      end
      chk(n, e);
   endtask
   task automatic do_reset(input logic m, input logic s);
      @(posedge clk_i);
      extended_pinout_mode_i <= m;
      pin1_native_strap_i <= s;
      rst_i <= 1'b1;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
   endtask
   task automatic t_regs(input logic [15:0] p1);
      logic [31:0] q;
      rd_chk(12'hc08, 32'h0);
      rd_chk(12'hc0c, 32'h8);
      rd_chk(12'hc10, {16'h0, p1});
      rd_chk(12'hc14, 32'h0);
      // a status write must not reach the io register either
      bus(1'b1, 12'hc20, 16'h0041, q);
      rd_chk(12'hc20, 32'h0);
      rd_chk(12'hc08, 32'h0);
      bus(1'b1, 12'he00, 16'hffff, q);
      rd_chk(12'he00, 32'h0);
      $display("regs done");
   endtask
   // every function code with both clock sources and two source patterns
   task automatic t_codes(input int p);
      logic [31:0] q;
      logic [5:0] r;
      for (int i = 0; i < 32; i++) begin
         r = {1'b1, i[4], ~i[4], i[2:0]};
         lvl <= plpfm_src_s'(i[3] ? 10'h2aa : 10'h155);
         bus(1'b1, 12'hc0c + 12'(4 * p), {10'h0, r}, q);
         repeat (5) @(posedge clk_i);
         chk(pins[p], plpfm_exp(p, r, lvl));
      end
      $display("codes done");
   endtask
   task automatic t_run;
      logic [31:0] q;
      run <= 1'b1;
      bus(1'b1, 12'hc0c, 16'h0029, q);
      bus(1'b1, 12'hc10, 16'h0031, q);
      bus(1'b1, 12'hc14, 16'h0001, q);
      repeat (5) @(posedge clk_i);
      rises(0, 8);
      rises(1, 4);
      rises(2, 0);
      bus(1'b1, 12'hc0c, 16'h0019, q);
      bus(1'b1, 12'hc10, 16'h002a, q);
      repeat (5) @(posedge clk_i);
      rises(0, 0);
      rises(1, 0);
      run <= 1'b0;
      $display("run done");
   endtask
   task automatic t_shared;
      logic [31:0] q;
      lvl <= plpfm_src_s'(10'h001);
      bus(1'b1, 12'hc10, 16'h0000, q);
      repeat (5) @(posedge clk_i);
      chk(pins[1], 32'h1);
      bus(1'b1, 12'hc08, 16'h0040, q);
      rd_chk(12'hc20, 32'h1);
      repeat (5) @(posedge clk_i);
      chk(pins[1], 32'h0);
      lvl <= plpfm_src_s'(10'h100);
      repeat (5) @(posedge clk_i);
      chk(pins[1], 32'h1);
      $display("shared done");
   endtask
   initial begin
      do_reset(1'b0, 1'b0);
      t_regs(16'h000d);
      t_codes(0);
      t_codes(1);
      t_codes(2);
      t_run;
      do_reset(1'b1, 1'b0);
      t_regs(16'h000e);
      t_shared;
      do_reset(1'b1, 1'b1);
      t_regs(16'h0008);
      test_done;
   end
endmodule
